// [hdl/sss_check.sv]
`default_nettype none
module sss_check
	import sss_pkg::*;
(
	sss_chk_if.chk c
);
	// -----------------------------------------------------------------
	// Mask, entry faults, header checks and modified-optimisation gate
	// -----------------------------------------------------------------
	logic [63:0] enabled;
	logic [1:0]  current_privilege_level;
	logic        misaligned;

	// The enabled set is user plus supervisor features.
	always_comb begin
		enabled    = c.ufe | c.sse;
		c.requested_component_mask     = c.imask & enabled;
		current_privilege_level        = c.ctrl[CTRL_CPL_LSB +: 2];
		misaligned = |(c.addr & ALIGN_MASK);
		// Invalid opcode outranks the task-switch trap, which outranks protection.
		if (!c.ctrl[CTRL_SFE_BIT]) begin
			c.entry_fault = FLT_UD;
		end else if (c.ctrl[CTRL_TS_BIT]) begin
			c.entry_fault = FLT_NM;
		end else if (misaligned && c.ctrl[CTRL_ACEN] && current_privilege_level == 2'h3) begin
			c.entry_fault = FLT_AC;
		end else if (current_privilege_level != 2'h0 || misaligned) begin
			c.entry_fault = FLT_GP;
		end else begin
			c.entry_fault = FLT_NONE;
		end
		// Header words are judged only after all eight were read.
		c.hdr_fault = !c.cv[TOP_BIT]
			|| |(c.cv[62:0] & ~enabled[62:0])
			|| |(c.ssv & ~c.cv)
			|| c.hdr_nz;
		c.mod_ok = c.t_valid && c.t_cpl == current_privilege_level
			&& c.t_nonroot == c.ctrl[CTRL_NONROOT]
			&& c.t_addr == c.addr
			&& c.t_cv[TOP_BIT]
			&& c.t_cv[62:0] == c.requested_component_mask[62:0];
	end
endmodule : sss_check
`default_nettype wire

// [hdl/sss_chk_if.sv]
`default_nettype none
interface sss_chk_if;
	import sss_pkg::*;
	logic [63:0]   imask;
	logic [63:0]   ufe;
	logic [63:0]   sse;
	logic [63:0]   addr;
	logic [10:0]   ctrl;
	logic [63:0]   ssv;
	logic [63:0]   cv;
	logic          hdr_nz;
	logic          t_valid;
	logic [1:0]    t_cpl;
	logic          t_nonroot;
	logic [63:0]   t_addr;
	logic [63:0]   t_cv;
	logic [63:0]   requested_component_mask;
	sss_fault_type entry_fault;
	logic          hdr_fault;
	logic          mod_ok;
	modport core (output imask, ufe, sse, addr, ctrl, ssv, cv, hdr_nz, t_valid, t_cpl,
		t_nonroot, t_addr, t_cv, input requested_component_mask, entry_fault, hdr_fault, mod_ok);
	modport chk (input imask, ufe, sse, addr, ctrl, ssv, cv, hdr_nz, t_valid, t_cpl,
		t_nonroot, t_addr, t_cv, output requested_component_mask, entry_fault, hdr_fault, mod_ok);
endinterface : sss_chk_if
`default_nettype wire

// [hdl/sss_pkg.sv]
`default_nettype none
package sss_pkg;
	// -----------------------------------------------------------------
	// Register byte offsets on the Wishbone slave
	// -----------------------------------------------------------------
	localparam logic [7:0] REG_CMD       = 8'h00;
	localparam logic [7:0] REG_CTRL      = 8'h04;
	localparam logic [7:0] REG_IMASK_LO  = 8'h08;
	localparam logic [7:0] REG_IMASK_HI  = 8'h0c;
	localparam logic [7:0] REG_UFE_LO    = 8'h10;
	localparam logic [7:0] REG_UFE_HI    = 8'h14;
	localparam logic [7:0] REG_SSE_LO    = 8'h18;
	localparam logic [7:0] REG_SSE_HI    = 8'h1c;
	localparam logic [7:0] REG_ADDR_LO   = 8'h20;
	localparam logic [7:0] REG_ADDR_HI   = 8'h24;
	localparam logic [7:0] REG_INUSE_LO  = 8'h28;
	localparam logic [7:0] REG_INUSE_HI  = 8'h2c;
	localparam logic [7:0] REG_MOD_LO    = 8'h30;
	localparam logic [7:0] REG_MOD_HI    = 8'h34;
	localparam logic [7:0] REG_CSR       = 8'h38;
	localparam logic [7:0] REG_SSV_LO    = 8'h3c;
	localparam logic [7:0] REG_SSV_HI    = 8'h40;
	localparam logic [7:0] REG_CV_LO     = 8'h44;
	localparam logic [7:0] REG_CV_HI     = 8'h48;
	localparam logic [7:0] REG_TUPLE     = 8'h4c;
	// -----------------------------------------------------------------
	// Field positions
	// -----------------------------------------------------------------
	localparam int CMD_SAVE_BIT    = 0;
	localparam int CMD_RESTORE_BIT = 1;
	localparam int CTRL_SFE_BIT    = 0;
	localparam int CTRL_TS_BIT     = 3;
	localparam int CTRL_CPL_LSB    = 4;
	localparam int CTRL_NONROOT    = 8;
	localparam int CTRL_MODE64     = 9;
	localparam int CTRL_ACEN       = 10;
	localparam int TOP_BIT         = 63;
	// -----------------------------------------------------------------
	// Reset values and fixed figures
	// -----------------------------------------------------------------
	localparam logic [31:0] CSR_INIT     = 32'h0000_1f80;
	localparam logic [31:0] CSR_LEGAL    = 32'h0000_ffff;
	localparam logic [63:0] ALIGN_MASK   = 64'h0000_0000_0000_003f;
	localparam logic [63:0] OFF_COMP1    = 64'h0000_0000_0000_00a0;
	localparam logic [63:0] OFF_HDR      = 64'h0000_0000_0000_0200;
	localparam logic [63:0] OFF_EXT      = 64'h0000_0000_0000_0240;
	localparam logic [63:0] COMP_BYTES   = 64'h0000_0000_0000_0040;
	localparam logic [63:0] WORD_BYTES   = 64'h0000_0000_0000_0008;
	localparam logic [2:0]  HDR_WORDS    = 3'h7;
	localparam logic [5:0]  LAST_COMP    = 6'h3e;
	// -----------------------------------------------------------------
	// Fault codes and memory-side operations
	// -----------------------------------------------------------------
	typedef enum logic [2:0] {
		FLT_NONE = 3'h0, FLT_UD = 3'h1, FLT_NM = 3'h2, FLT_GP = 3'h3, FLT_AC = 3'h4
	} sss_fault_type;
	typedef enum logic [2:0] {
		OP_HDR_WR = 3'h0, OP_HDR_RD = 3'h1, OP_SAVE = 3'h2, OP_LOAD = 3'h3, OP_INIT = 3'h4
	} sss_op_type;
endpackage : sss_pkg
`default_nettype wire

// [hdl/sss_top.sv]
`default_nettype none
module sss_top
	import sss_pkg::*;
(
	// Clock, reset, enable
	input  wire logic        core_clk_i,
	input  wire logic        rst_i,
	input  wire logic        ce_i,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Save-area memory and state datapath
	output logic             mem_req_o,
	output logic      [2:0]  mem_op_o,
	output logic      [5:0]  mem_comp_o,
	output logic      [63:0] mem_addr_o,
	output logic      [63:0] mem_wdata_o,
	output logic             mem_long_mode_o,
	input  wire logic        mem_ack_i,
	input  wire logic [63:0] mem_rdata_i,
	input  wire logic        mem_err_i
);
	// -----------------------------------------------------------------
	// State
	// -----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE, ST_HDR_RD, ST_HDR_CHK, ST_COMP, ST_COMP_WAIT, ST_HDR_WR
	} sss_state_type;

	typedef struct packed {
		sss_state_type state;
		logic          busy;
		logic          done;
		sss_fault_type fault;
		logic          restore;
		logic [10:0]   ctrl;
		logic [63:0]   imask;
		logic [63:0]   ufe;
		logic [63:0]   sse;
		logic [63:0]   addr;
		logic [63:0]   in_use;
		logic [63:0]   modified;
		logic [31:0]   csr;
		logic [63:0]   ssv;
		logic [63:0]   cv;
		logic          hdr_nz;
		logic [5:0]    idx;
		logic [2:0]    word;
		logic [63:0]   ext_off;
		logic [63:0]   requested_component_mask;
		logic          mod_ok;
		logic          t_valid;
		logic [1:0]    t_cpl;
		logic          t_nonroot;
		logic [63:0]   t_addr;
		logic [63:0]   t_cv;
		logic          ack;
		logic [31:0]   rdat;
		logic          req;
		sss_op_type    op;
		logic [5:0]    comp;
		logic [63:0]   maddr;
		logic [63:0]   wdata;
	} sss_regs_type;

	sss_regs_type r;
	sss_regs_type next_r;
	sss_chk_if    chk ();

	// -----------------------------------------------------------------
	// Checks and mask unit
	// -----------------------------------------------------------------
	sss_check u_check (
		.c (chk.chk)
	);

	assign chk.imask     = r.imask;
	assign chk.ufe       = r.ufe;
	assign chk.sse       = r.sse;
	assign chk.addr      = r.addr;
	assign chk.ctrl      = r.ctrl;
	assign chk.ssv       = r.ssv;
	assign chk.cv        = r.cv;
	assign chk.hdr_nz    = r.hdr_nz;
	assign chk.t_valid   = r.t_valid;
	assign chk.t_cpl     = r.t_cpl;
	assign chk.t_nonroot = r.t_nonroot;
	assign chk.t_addr    = r.t_addr;
	assign chk.t_cv      = r.t_cv;

	// Byte-lane merge for one 32-bit register word: a half of a 64-bit register, CTRL or CSR.
	function automatic logic [31:0] lane_wr(input logic [31:0] old, input logic [31:0] dat,
		input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				res[8*b +: 8] = dat[8*b +: 8];
			end
		end
		return res;
	endfunction : lane_wr

	// -----------------------------------------------------------------
	// Next-state logic
	// -----------------------------------------------------------------
	logic        bus_req;
	logic        bus_wr;
	logic        csr_ne;
	logic        do_save;
	logic        last;
	logic [63:0] comp_addr;

	// Bus access, sequencer and tracker updates in one pass.
	always_comb begin
		next_r    = r;
		bus_req   = wb_cyc_i && wb_stb_i && !r.ack;
		bus_wr    = bus_req && wb_we_i && !r.busy;
		csr_ne    = r.csr != CSR_INIT;
		last      = r.idx == LAST_COMP;
		do_save   = 1'b0;
		comp_addr = r.addr + r.ext_off;
		if (r.idx == 6'h0) begin
			comp_addr = r.addr;
		end else if (r.idx == 6'h1) begin
			comp_addr = r.addr + OFF_COMP1;
		end
		next_r.ack = bus_req;
		// Reads return zero for unmapped offsets; writes to them are dropped.
		unique case (wb_adr_i)
			REG_CMD:      next_r.rdat = {25'h0, r.fault, 2'h0, r.done, r.busy};
			REG_CTRL:     next_r.rdat = {21'h0, r.ctrl};
			REG_IMASK_LO: next_r.rdat = r.imask[31:0];
			REG_IMASK_HI: next_r.rdat = r.imask[63:32];
			REG_UFE_LO:   next_r.rdat = r.ufe[31:0];
			REG_UFE_HI:   next_r.rdat = r.ufe[63:32];
			REG_SSE_LO:   next_r.rdat = r.sse[31:0];
			REG_SSE_HI:   next_r.rdat = r.sse[63:32];
			REG_ADDR_LO:  next_r.rdat = r.addr[31:0];
			REG_ADDR_HI:  next_r.rdat = r.addr[63:32];
			REG_INUSE_LO: next_r.rdat = r.in_use[31:0];
			REG_INUSE_HI: next_r.rdat = r.in_use[63:32];
			REG_MOD_LO:   next_r.rdat = r.modified[31:0];
			REG_MOD_HI:   next_r.rdat = r.modified[63:32];
			REG_CSR:      next_r.rdat = r.csr;
			REG_SSV_LO:   next_r.rdat = r.ssv[31:0];
			REG_SSV_HI:   next_r.rdat = r.ssv[63:32];
			REG_CV_LO:    next_r.rdat = r.cv[31:0];
			REG_CV_HI:    next_r.rdat = r.cv[63:32];
			REG_TUPLE:    next_r.rdat = {28'h0, r.t_valid, r.t_nonroot, r.t_cpl};
			default:      next_r.rdat = 32'h0;
		endcase
		// Writes while busy are ignored so the operands cannot shift mid-flight.
		if (bus_wr) begin
			unique case (wb_adr_i)
				REG_CTRL:     next_r.ctrl = 11'(lane_wr({21'h0, r.ctrl}, wb_dat_i, wb_sel_i));
				REG_IMASK_LO: next_r.imask[31:0] = lane_wr(r.imask[31:0], wb_dat_i, wb_sel_i);
				REG_IMASK_HI: next_r.imask[63:32] = lane_wr(r.imask[63:32], wb_dat_i, wb_sel_i);
				REG_UFE_LO:   next_r.ufe[31:0] = lane_wr(r.ufe[31:0], wb_dat_i, wb_sel_i);
				REG_UFE_HI:   next_r.ufe[63:32] = lane_wr(r.ufe[63:32], wb_dat_i, wb_sel_i);
				REG_SSE_LO:   next_r.sse[31:0] = lane_wr(r.sse[31:0], wb_dat_i, wb_sel_i);
				REG_SSE_HI:   next_r.sse[63:32] = lane_wr(r.sse[63:32], wb_dat_i, wb_sel_i);
				REG_ADDR_LO:  next_r.addr[31:0] = lane_wr(r.addr[31:0], wb_dat_i, wb_sel_i);
				REG_ADDR_HI:  next_r.addr[63:32] = lane_wr(r.addr[63:32], wb_dat_i, wb_sel_i);
				REG_INUSE_LO: next_r.in_use[31:0] = lane_wr(r.in_use[31:0], wb_dat_i, wb_sel_i);
				REG_INUSE_HI: next_r.in_use[63:32] = lane_wr(r.in_use[63:32], wb_dat_i, wb_sel_i);
				REG_MOD_LO:   next_r.modified[31:0] = lane_wr(r.modified[31:0], wb_dat_i, wb_sel_i);
				REG_MOD_HI:   next_r.modified[63:32] = lane_wr(r.modified[63:32], wb_dat_i, wb_sel_i);
				REG_CSR:      next_r.csr = lane_wr(r.csr, wb_dat_i, wb_sel_i);
				default:      next_r.ctrl = r.ctrl;
			endcase
		end
		unique case (r.state)
			ST_IDLE: begin
				// Entry faults are settled here, before anything leaves the block.
				if (bus_wr && wb_adr_i == REG_CMD && wb_sel_i[0]
					&& (wb_dat_i[CMD_SAVE_BIT] || wb_dat_i[CMD_RESTORE_BIT])) begin
					next_r.done    = 1'b0;
					next_r.restore = wb_dat_i[CMD_RESTORE_BIT] && !wb_dat_i[CMD_SAVE_BIT];
					next_r.requested_component_mask    = chk.requested_component_mask;
					next_r.mod_ok  = chk.mod_ok;
					next_r.fault   = chk.entry_fault;
					next_r.idx     = 6'h0;
					next_r.word    = 3'h0;
					next_r.ext_off = OFF_EXT;
					next_r.hdr_nz  = 1'b0;
					if (chk.entry_fault != FLT_NONE) begin
						next_r.done = 1'b1;
					end else if (next_r.restore) begin
						next_r.busy  = 1'b1;
						next_r.state = ST_HDR_RD;
						next_r.req   = 1'b1;
						next_r.op    = OP_HDR_RD;
						next_r.maddr = r.addr + OFF_HDR;
					end else begin
						next_r.busy  = 1'b1;
						next_r.state = ST_COMP;
					end
				end
			end
			ST_HDR_RD: begin
				// Eight words: vector, compaction vector, then six that must be zero.
				if (mem_ack_i) begin
					if (r.word == 3'h0) begin
						next_r.ssv = mem_rdata_i;
					end else if (r.word == 3'h1) begin
						next_r.cv = mem_rdata_i;
					end else begin
						next_r.hdr_nz = r.hdr_nz || |mem_rdata_i;
					end
					next_r.word  = r.word + 3'h1;
					next_r.maddr = r.maddr + WORD_BYTES;
					if (r.word == HDR_WORDS) begin
						next_r.req   = 1'b0;
						next_r.state = ST_HDR_CHK;
					end
				end
			end
			ST_HDR_CHK: begin
				if (chk.hdr_fault) begin
					next_r.fault = FLT_GP;
					next_r.busy  = 1'b0;
					next_r.done  = 1'b1;
					next_r.state = ST_IDLE;
				end else begin
					next_r.state = ST_COMP;
				end
			end
			ST_COMP: begin
				// One component per visit; skipped ones cost a single cycle.
				next_r.comp = r.idx;
				next_r.maddr = comp_addr;
				if (r.restore) begin
					if (r.requested_component_mask[r.idx]) begin
						do_save = 1'b1;
						next_r.op = r.ssv[r.idx] ? OP_LOAD : OP_INIT;
					end
				end else begin
					do_save = r.requested_component_mask[r.idx]
						&& (r.in_use[r.idx] || (r.idx == 6'h1 && csr_ne))
						&& !(r.mod_ok && !r.modified[r.idx]
							&& !(r.idx == 6'h1 && csr_ne));
					next_r.op    = OP_SAVE;
					next_r.wdata = (r.idx == 6'h1) ? {32'h0, r.csr} : 64'h0;
				end
				// The extended offset advances for every compacted slot, saved or not.
				if (r.idx >= 6'h2 && (r.restore ? r.cv[r.idx] : r.requested_component_mask[r.idx])) begin
					next_r.ext_off = r.ext_off + COMP_BYTES;
				end
				if (do_save) begin
					next_r.req   = 1'b1;
					next_r.state = ST_COMP_WAIT;
				end else begin
					next_r.idx = r.idx + 6'h1;
					if (last) begin
						next_r.state = ST_HDR_WR;
					end
				end
			end
			ST_COMP_WAIT: begin
				if (mem_ack_i) begin
					next_r.req = 1'b0;
					next_r.idx = r.idx + 6'h1;
					next_r.state = last ? ST_HDR_WR : ST_COMP;
					if (r.restore && r.op == OP_INIT && r.idx == 6'h1) begin
						next_r.csr = CSR_INIT;
					end
					// Earlier components keep what they already took on abort.
					if (r.restore && r.op == OP_LOAD
						&& ((mem_err_i && r.sse[r.idx])
						|| (r.idx == 6'h1 && |(mem_rdata_i[31:0] & ~CSR_LEGAL)))) begin
						next_r.fault = FLT_GP;
						next_r.busy  = 1'b0;
						next_r.done  = 1'b1;
						next_r.state = ST_IDLE;
					end else if (r.restore && r.op == OP_LOAD && r.idx == 6'h1) begin
						next_r.csr = mem_rdata_i[31:0];
					end
				end
			end
			ST_HDR_WR: begin
				if (r.restore) begin
					// Trackers and tuple change only when the restore completes.
					next_r.in_use   = r.in_use | (r.requested_component_mask & r.ssv);
					next_r.modified = ~r.requested_component_mask;
					next_r.t_valid   = 1'b1;
					next_r.t_cpl     = r.ctrl[CTRL_CPL_LSB +: 2];
					next_r.t_nonroot = r.ctrl[CTRL_NONROOT];
					next_r.t_addr    = r.addr;
					next_r.t_cv      = r.cv;
					next_r.busy      = 1'b0;
					next_r.done      = 1'b1;
					next_r.state     = ST_IDLE;
				end else if (!r.req) begin
					// First the saved-state vector, then the compaction vector; nothing else.
					next_r.req   = 1'b1;
					next_r.op    = OP_HDR_WR;
					next_r.word  = 3'h0;
					next_r.maddr = r.addr + OFF_HDR;
					next_r.wdata = r.requested_component_mask & r.in_use;
					next_r.wdata[1] = r.requested_component_mask[1] && (r.in_use[1] || csr_ne);
					next_r.ssv   = next_r.wdata;
					next_r.cv    = {1'b1, r.requested_component_mask[62:0]};
				end else if (mem_ack_i) begin
					if (r.word == 3'h0) begin
						next_r.word  = 3'h1;
						next_r.maddr = r.maddr + WORD_BYTES;
						next_r.wdata = r.cv;
					end else begin
						next_r.req   = 1'b0;
						next_r.busy  = 1'b0;
						next_r.done  = 1'b1;
						next_r.state = ST_IDLE;
					end
				end
			end
		endcase
	end

	// -----------------------------------------------------------------
	// State register
	// -----------------------------------------------------------------
	// All state freezes while the clock enable is low.
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			r       <= '0;
			r.state <= ST_IDLE;
			r.fault <= FLT_NONE;
			r.op    <= OP_HDR_WR;
			r.csr   <= CSR_INIT;
		end else if (ce_i) begin
			r <= next_r;
		end
	end

	// -----------------------------------------------------------------
	// Outputs
	// -----------------------------------------------------------------
	assign wb_ack_o        = r.ack;
	assign wb_dat_o        = r.rdat;
	assign mem_req_o       = r.req;
	assign mem_op_o        = r.op;
	assign mem_comp_o      = r.comp;
	assign mem_addr_o      = r.maddr;
	assign mem_wdata_o     = r.wdata;
	assign mem_long_mode_o = r.ctrl[CTRL_MODE64];
endmodule : sss_top
`default_nettype wire

// [verification/sss_mem_model.sv]
`default_nettype none
module sss_mem_model
	import sss_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Request from the block
	input  wire logic        req_i,
	input  wire logic [2:0]  op_i,
	input  wire logic [5:0]  comp_i,
	input  wire logic [63:0] addr_i,
	input  wire logic [63:0] wdata_i,
	// Answer to the block
	output logic             ack_o,
	output logic      [63:0] rdata_o,
	output logic             err_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [63:0] mem [logic [63:0]];
	logic [2:0]  log_op [$];
	logic [63:0] log_a [$];
	logic [63:0] log_d [$];
	int          wait_n = 0;
	logic [5:0]  bad_comp = 6'h3f;
	int          cnt;
	// Answer after wait_n cycles. Idle read data toggles so a stale word never passes.
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			err_o <= 1'b0;
			rdata_o <= 64'h0;
			cnt <= 0;
		end else begin
			ack_o <= 1'b0;
			err_o <= 1'b0;
			rdata_o <= ~rdata_o;
			if (req_i && !ack_o && cnt < wait_n) begin
				cnt <= cnt + 1;
			end else if (req_i && !ack_o) begin
				cnt <= 0;
				ack_o <= 1'b1;
				rdata_o <= mem.exists(addr_i) ? mem[addr_i] : 64'h0;
				err_o <= op_i == OP_LOAD && comp_i == bad_comp;
				if (op_i == OP_HDR_WR || op_i == OP_SAVE) mem[addr_i] = wdata_i;
				log_op.push_back(op_i);
				log_a.push_back(addr_i);
				log_d.push_back(wdata_i);
			end
		end
	end
endmodule : sss_mem_model
`default_nettype wire

// [verification/sss_top_bench.sv]
`default_nettype none
module sss_top_bench
	import sss_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst, cyc, stb, we, mreq, mlong, mack, merr, ack;
	logic [7:0] adr;
	logic [31:0] dat, rdat, q;
	logic [2:0] mop;
	logic [5:0] mcomp;
	logic [63:0] maddr, mwd, mrd;
	int failures = 0;
	int tests_run = 0;
	// Entry fault cases: control word, area address, expected fault code.
	logic [31:0] fc [5] = '{32'h0, 32'h9, 32'h11, 32'h1, 32'h431};
	logic [63:0] fa [5] = '{64'h1000, 64'h1000, 64'h1000, 64'h1010, 64'h1010};
	logic [2:0] ff [5] = '{3'h1, 3'h2, 3'h3, 3'h3, 3'h4};
	// Bad restore cases: vectors, header word 2, component 1 word, failing load, log size.
	logic [63:0] h0 [6] = '{64'h0, 64'h0, 64'h10, 64'h0, 64'h2, 64'h100};
	logic [63:0] h1 [6] = '{64'h107, 64'h8000_0000_0000_0127, 64'h8000_0000_0000_0107,
		64'h8000_0000_0000_0107, 64'h8000_0000_0000_0002, 64'h8000_0000_0000_0100};
	logic [63:0] h2 [6] = '{64'h0, 64'h0, 64'h0, 64'h1, 64'h0, 64'h0};
	logic [63:0] c1 [6] = '{64'h0, 64'h0, 64'h0, 64'h0, 64'h1_0000, 64'h0};
	logic [5:0] bc [6] = '{6'h3f, 6'h3f, 6'h3f, 6'h3f, 6'h3f, 6'h08};
	int ls [6] = '{8, 8, 8, 8, 10, 12};
	sss_top dut (.core_clk_i(clk), .rst_i(rst), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .mem_req_o(mreq), .mem_op_o(mop), .mem_comp_o(mcomp),
		.mem_addr_o(maddr), .mem_wdata_o(mwd), .mem_long_mode_o(mlong), .mem_ack_i(mack),
		.mem_rdata_i(mrd), .mem_err_i(merr));
	sss_mem_model m (.clk_i(clk), .rst_i(rst), .req_i(mreq), .op_i(mop), .comp_i(mcomp),
		.addr_i(maddr), .wdata_i(mwd), .ack_o(mack), .rdata_o(mrd), .err_o(merr));
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic report_and_stop;
		if (failures == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [63:0] s, input logic [63:0] e);
		tests_run++;
		if (s !== e) begin
			failures++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	// Classic single cycle; the request is held until ack is sampled high.
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		int n;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 100);
		r = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 100) begin
			chk(1, 0);
			report_and_stop();
		end
	endtask : wb
	task automatic w64(input logic [7:0] a, input logic [63:0] v);
		wb(1'b1, a, v[31:0], q);
		wb(1'b1, a + 8'h4, v[63:32], q);
	endtask : w64
	// Start a command and poll until busy clears; the request log starts empty.
	task automatic run(input logic [1:0] c, output logic [31:0] s);
		int n;
		m.log_op.delete();
		m.log_a.delete();
		m.log_d.delete();
		wb(1'b1, REG_CMD, {30'h0, c}, s);
		n = 0;
		do begin
			wb(1'b0, REG_CMD, 32'h0, s);
			n++;
		end while (s[0] !== 1'b0 && n < 500);
		if (n >= 500) begin
			chk(1, 0);
			report_and_stop();
		end
	endtask : run
	// Init requests carry no checked address, since nothing is moved for them.
	task automatic ex(input logic [2:0] op, input logic [63:0] a, input logic [63:0] d);
		logic [2:0] po;
		logic [63:0] pa, pd;
		po = 3'h7;
		pa = '1;
		pd = '1;
		if (m.log_a.size() > 0) begin
			po = m.log_op.pop_front();
			pa = m.log_a.pop_front();
			pd = m.log_d.pop_front();
		end
		chk({61'h0, po}, {61'h0, op});
		if (op != OP_INIT) chk(pa, a);
		if (op == OP_HDR_WR) chk(pd, d);
	endtask : ex
	// ------------------------------------------------------------
	// Clock, watchdog and test sequence
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		#500000;
		failures++;
		report_and_stop();
	end
	initial begin
		{rst, cyc, stb, we, adr, dat} = {1'b1, 43'h0};
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		wb(1'b0, REG_CSR, 32'h0, q);
		chk(q, CSR_INIT);
		for (int i = 0; i < 5; i++) begin
			for (int c = 1; c < 3; c++) begin
				w64(REG_ADDR_LO, fa[i]);
				wb(1'b1, REG_CTRL, fc[i], q);
				run(c[1:0], q);
				chk(q[6:4], ff[i]);
				chk(m.log_a.size(), 0);
				chk(mlong, 0);
			end
		end
		w64(REG_IMASK_LO, ~64'h8);
		w64(REG_UFE_LO, 64'hf);
		w64(REG_SSE_LO, 64'h100);
		w64(REG_ADDR_LO, 64'h1000);
		w64(REG_INUSE_LO, 64'h0000_0100_0000_010d);
		wb(1'b1, REG_CSR, 32'h1f81, q);
		wb(1'b1, REG_CTRL, 32'h201, q);
		run(2'h1, q);
		chk(mlong, 1);
		ex(OP_SAVE, 64'h1000, 0);
		ex(OP_SAVE, 64'h10a0, 0);
		ex(OP_SAVE, 64'h1240, 0);
		ex(OP_SAVE, 64'h1280, 0);
		ex(OP_HDR_WR, 64'h1200, 64'h107);
		ex(OP_HDR_WR, 64'h1208, 64'h8000_0000_0000_0107);
		chk(m.log_a.size(), 0);
		m.mem[64'h1200] = 64'h103;
		run(2'h2, q);
		for (int k = 0; k < 8; k++) ex(OP_HDR_RD, 64'h1200 + 8 * k, 0);
		ex(OP_LOAD, 64'h1000, 0);
		ex(OP_LOAD, 64'h10a0, 0);
		ex(OP_INIT, 0, 0);
		ex(OP_LOAD, 64'h1280, 0);
		wb(1'b0, REG_INUSE_LO, 32'h0, q);
		chk(q, 32'h10f);
		wb(1'b0, REG_MOD_LO, 32'h0, q);
		chk(q, 32'hffff_fef8);
		wb(1'b0, REG_TUPLE, 32'h0, q);
		chk(q, 32'h8);
		wb(1'b0, REG_CV_HI, 32'h0, q);
		chk(q, 32'h8000_0000);
		wb(1'b1, REG_CSR, 32'h1f81, q);
		run(2'h1, q);
		ex(OP_SAVE, 64'h10a0, 0);
		ex(OP_HDR_WR, 64'h1200, 64'h107);
		ex(OP_HDR_WR, 64'h1208, 64'h8000_0000_0000_0107);
		w64(REG_ADDR_LO, 64'h1040);
		m.wait_n = 2;
		run(2'h1, q);
		chk(m.log_a.size(), 6);
		w64(REG_ADDR_LO, 64'h2000);
		for (int i = 0; i < 6; i++) begin
			m.mem[64'h2200] = h0[i];
			m.mem[64'h2208] = h1[i];
			m.mem[64'h2210] = h2[i];
			m.mem[64'h20a0] = c1[i];
			m.bad_comp = bc[i];
			run(2'h2, q);
			chk(q[6:4], 3'h3);
			chk(m.log_a.size(), ls[i]);
		end
		wb(1'b0, REG_CSR, 32'h0, q);
		chk(q, CSR_INIT);
		report_and_stop();
	end
endmodule : sss_top_bench
`default_nettype wire

// [verification/sss_top_chk.sv]
`default_nettype none
module sss_top_chk
	import sss_pkg::*;
(
	// Clock, reset, enable
	input wire logic        core_clk_i,
	input wire logic        rst_i,
	input wire logic        ce_i,
	// Bus handshake
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_ack_o,
	// Save-area requests
	input wire logic        mem_req_o,
	input wire logic [2:0]  mem_op_o,
	input wire logic [5:0]  mem_comp_o,
	input wire logic [63:0] mem_addr_o,
	input wire logic [63:0] mem_wdata_o,
	input wire logic        mem_ack_i
);
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	// One clock domain, so clocking and reset are declared once.
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (rst_i);
	AST_WB_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && ce_i && !wb_ack_o |=> wb_ack_o)
		else $error("Bus access not answered in the next cycle.");
	AST_WB_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("Bus acknowledge longer than one cycle.");
	AST_MEM_HOLD: assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_op_o)
		&& $stable(mem_addr_o) && $stable(mem_wdata_o))
		else $error("Memory request changed before its answer.");
	AST_HDR_FIELDS: assert property (mem_req_o && mem_op_o == OP_HDR_WR |->
		mem_addr_o[5:0] == 6'h00 || mem_addr_o[5:0] == 6'h08)
		else $error("Header write outside the two vector fields.");
	AST_CV_TOP: assert property (mem_req_o && mem_op_o == OP_HDR_WR
		&& mem_addr_o[5:0] == 6'h08 |-> mem_wdata_o[63])
		else $error("Compaction vector written with top bit clear.");
	AST_COMP_SLOT: assert property (mem_req_o && (mem_op_o == OP_SAVE || mem_op_o == OP_LOAD)
		|-> mem_addr_o[5:0] == ((mem_comp_o == 6'h01) ? 6'h20 : 6'h00))
		else $error("Component placed at a wrong slot offset.");
	AST_COMP_RANGE: assert property (mem_req_o && mem_op_o inside {OP_SAVE, OP_LOAD, OP_INIT}
		|-> mem_comp_o <= 6'h3e)
		else $error("Component index above the last one.");
	AST_HDR_STEP: assert property (mem_req_o && mem_op_o == OP_HDR_RD && mem_ack_i
		&& mem_addr_o[5:0] != 6'h38 |=> mem_req_o && mem_op_o == OP_HDR_RD
		&& mem_addr_o == $past(mem_addr_o) + 64'h8)
		else $error("Header read did not step to the next word.");
endmodule : sss_top_chk
bind sss_top sss_top_chk u_chk (.core_clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
	.mem_req_o, .mem_op_o, .mem_comp_o, .mem_addr_o, .mem_wdata_o, .mem_ack_i);
`default_nettype wire
